// ===== hdl/hd_video_mode_registers.v
// High definition video mode register bank with its decoded controls
`timescale 1ns/10ps
// ****************************************************************
// How it works
// - Level field picks component, alternative, full range
// - Sync from embedded codes or external pins
// - Vertical select bit: field indicator or vsync
// - Five-bit standard picks timing; others reserved
// - Pixel data valid bit switches function
// - Oversample bit: zero four times, one twice
// - Test pattern enable replaces incoming video
// - Pattern type bit: hatch or flat field
// - Bit passes active data through blanking interval
// - Luma and colour delay by cycle counts
// - Separate copy data and checksum enables
// - Sinc filter enable for all DACs
// - Timing reset bit holds counters cleared
// - One bit per sync output pin choice
// - Counter mode: standard update or free running
// - Swap bit exchanges colour difference DACs
// - Curve select picks gamma curve A/B
// - Gamma applied only when enable set
// - Adaptive mode used only when enabled
// - Three pattern levels, resets A0, 80, 80
// - Free running wraps only while timing reset is clear
// - Pattern levels effective only with pattern enabled
// ****************************************************************
`include "hd_mode_regs.vh"
module hd_video_mode_registers (
  input  wire       clk,
  input  wire       rst,
  input  wire       clk_en,
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data,
  output wire       rd_valid,
  output reg  [1:0] level_mode,
  output reg        level_reserved,
  output reg        sync_embedded,
  output reg        ext_vsync_is_vsync,
  output reg        ext_vsync_is_field,
  output reg  [4:0] video_std,
  output reg        std_nonstandard,
  output reg        std_reserved,
  output reg        pixel_valid_on,
  output reg        oversample_2x,
  output reg        pattern_on,
  output reg        pattern_flat,
  output reg        vbi_open,
  output reg  [2:0] luma_delay,
  output reg  [2:0] chroma_delay,
  output reg        cgms_on,
  output reg        cgms_crc_on,
  output reg        sinc_on,
  output reg        timing_hold,
  output reg        hsync_out_sel,
  output reg        vsync_out_sel,
  output reg        counter_free,
  output reg        dac_swap,
  output reg        gamma_on,
  output reg        gamma_curve_b,
  output reg        adapt_on,
  output reg        adapt_mode_b,
  output reg  [7:0] pat_luma,
  output reg  [7:0] pat_red,
  output reg  [7:0] pat_blue,
  output reg        wrap_external
);

  reg [7:0] mode1_q;
  reg [7:0] mode2_q;
  reg [7:0] mode3_q;
  reg [7:0] mode4_q;
  reg [7:0] mode5_q;
  reg [7:0] mode6_q;
  reg [7:0] luma_q;
  reg [7:0] red_q;
  reg [7:0] blue_q;
  reg [4:0] std_safe;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function in_bank;
    input [7:0] a;
    begin
      in_bank = (a >= `OFS_MODE_ONE) && (a <= `OFS_BLUE_LEVEL);
    end
  endfunction

  // One hit per register; the enable term carries the freeze
  function wr_hit;
    input       en;
    input [7:0] a;
    input [7:0] ofs;
    begin
      wr_hit = en && (a == ofs);
    end
  endfunction

  assign rd_valid = in_bank(rd_addr);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode1_q <= `RST_MODE_ONE;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_MODE_ONE)) begin
      mode1_q <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode2_q <= `RST_MODE_TWO;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_MODE_TWO)) begin
      mode2_q <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode3_q <= `RST_MODE_THREE;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_MODE_THREE)) begin
      mode3_q <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode4_q <= `RST_MODE_FOUR;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_MODE_FOUR)) begin
      mode4_q <= wr_data;
    end
  end

  // Reserved bit is kept at zero in case the host slips
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode5_q <= `RST_MODE_FIVE;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_MODE_FIVE)) begin
      mode5_q <= wr_data & ~(8'h01 << `RSVD5_BIT);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode6_q <= `RST_MODE_SIX;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_MODE_SIX)) begin
      mode6_q <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      luma_q <= `RST_LUMA_LEVEL;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_LUMA_LEVEL)) begin
      luma_q <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      red_q <= `RST_RED_LEVEL;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_RED_LEVEL)) begin
      red_q <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      blue_q <= `RST_BLUE_LEVEL;
    end else if (wr_hit(clk_en & wr_en, wr_addr, `OFS_BLUE_LEVEL)) begin
      blue_q <= wr_data;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (clk_en) begin
      case (rd_addr)
        `OFS_MODE_ONE:   rd_data <= mode1_q;
        `OFS_MODE_TWO:   rd_data <= mode2_q;
        `OFS_MODE_THREE: rd_data <= mode3_q;
        `OFS_MODE_FOUR:  rd_data <= mode4_q;
        `OFS_MODE_FIVE:  rd_data <= mode5_q;
        `OFS_MODE_SIX:   rd_data <= mode6_q;
        `OFS_LUMA_LEVEL: rd_data <= luma_q;
        `OFS_RED_LEVEL:  rd_data <= red_q;
        `OFS_BLUE_LEVEL: rd_data <= blue_q;
        default:         rd_data <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Standard decode
  // ****************************************************************
  // Reserved codes fall back to nonstandard timing so no undefined
  // timing state can reach the generator
  always @* begin
    std_safe = mode1_q[`STD_LSB +: 5];
    if (std_safe > `STD_LAST || std_safe == `STD_RSVD_A ||
        std_safe == `STD_RSVD_B) begin
      std_safe = `STD_NONSTD;
    end
  end

  // ****************************************************************
  // Level, sync source and standard controls
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      level_mode         <= 2'h0;
      level_reserved     <= 1'b0;
      sync_embedded      <= 1'b0;
      ext_vsync_is_vsync <= 1'b0;
      ext_vsync_is_field <= 1'b0;
      video_std          <= 5'h00;
      std_nonstandard    <= 1'b0;
      std_reserved       <= 1'b0;
    end else if (clk_en) begin
      level_mode     <= mode1_q[`LEVEL_LSB +: 2];
      level_reserved <= mode1_q[`LEVEL_LSB +: 2] == `LEVEL_RESERVED;
      sync_embedded  <= mode1_q[`SYNC_EMBED_BIT];
      ext_vsync_is_vsync <= ~mode1_q[`SYNC_EMBED_BIT] &
                            mode5_q[`VSIN_SEL_BIT];
      ext_vsync_is_field <= ~mode1_q[`SYNC_EMBED_BIT] &
                            ~mode5_q[`VSIN_SEL_BIT];
      video_std      <= std_safe;
      std_nonstandard <= std_safe == `STD_NONSTD;
      std_reserved   <= std_safe != mode1_q[`STD_LSB +: 5];
    end
  end

  // ****************************************************************
  // Pixel and test pattern controls
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pixel_valid_on     <= 1'b0;
      oversample_2x      <= 1'b0;
      pattern_on         <= 1'b0;
      pattern_flat       <= 1'b0;
      vbi_open           <= 1'b0;
    end else if (clk_en) begin
      pixel_valid_on <= mode2_q[`PDV_BIT];
      oversample_2x  <= mode2_q[`OVS_BIT];
      pattern_on     <= mode2_q[`TP_EN_BIT];
      pattern_flat   <= mode2_q[`TP_FLAT_BIT];
      vbi_open       <= mode2_q[`VBI_OPEN_BIT];
    end
  end

  // ****************************************************************
  // Delay and copy data controls
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      luma_delay         <= 3'h0;
      chroma_delay       <= 3'h0;
      cgms_on            <= 1'b0;
      cgms_crc_on        <= 1'b0;
    end else if (clk_en) begin
      luma_delay     <= mode3_q[`LUMA_DLY_LSB +: 3];
      chroma_delay   <= mode3_q[`CHROMA_DLY_LSB +: 3];
      cgms_on        <= mode3_q[`CGMS_EN_BIT];
      cgms_crc_on    <= mode3_q[`CGMS_CRC_BIT];
    end
  end

  // ****************************************************************
  // Output filter control
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sinc_on            <= 1'b0;
    end else if (clk_en) begin
      sinc_on        <= mode4_q[`SINC_BIT];
    end
  end

  // ****************************************************************
  // Timing counter and sync output controls
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timing_hold        <= 1'b0;
      hsync_out_sel      <= 1'b0;
      vsync_out_sel      <= 1'b0;
      counter_free       <= 1'b0;
      wrap_external      <= 1'b0;
    end else if (clk_en) begin
      timing_hold    <= mode5_q[`TRST_BIT];
      hsync_out_sel  <= mode5_q[`HS_CTL_BIT];
      vsync_out_sel  <= mode5_q[`VS_CTL_BIT];
      counter_free   <= mode5_q[`CNT_FREE_BIT];
      // Free running wrap only needs the timing reset bit to be clear
      wrap_external  <= mode5_q[`CNT_FREE_BIT] &
                        ~mode5_q[`TRST_BIT];
    end
  end

  // ****************************************************************
  // Colour, gamma and adaptive filter controls
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_swap           <= 1'b0;
      gamma_on           <= 1'b0;
      gamma_curve_b      <= 1'b0;
      adapt_on           <= 1'b0;
      adapt_mode_b       <= 1'b0;
    end else if (clk_en) begin
      dac_swap       <= mode6_q[`SWAP_BIT];
      gamma_curve_b  <= mode6_q[`GAMMA_B_BIT];
      gamma_on       <= mode6_q[`GAMMA_EN_BIT];
      adapt_on       <= mode6_q[`AF_EN_BIT];
      adapt_mode_b   <= mode6_q[`AF_EN_BIT] &
                        mode6_q[`AF_MODE_BIT];
    end
  end

  // ****************************************************************
  // Test pattern levels
  // ****************************************************************
  // Level outputs are zero when no pattern runs; readback still returns the registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pat_luma           <= 8'h00;
      pat_red            <= 8'h00;
      pat_blue           <= 8'h00;
    end else if (clk_en) begin
      pat_luma <= mode2_q[`TP_EN_BIT] ? luma_q : 8'h00;
      pat_red  <= mode2_q[`TP_EN_BIT] ? red_q  : 8'h00;
      pat_blue <= mode2_q[`TP_EN_BIT] ? blue_q : 8'h00;
    end
  end

endmodule // hd_video_mode_registers

// ===== hdl/hd_mode_regs.vh
// Offsets, field positions, reset values and codes of the high definition mode bank
`ifndef HD_MODE_REGS_VH
`define HD_MODE_REGS_VH
`define OFS_MODE_ONE        8'h30
`define OFS_MODE_TWO        8'h31
`define OFS_MODE_THREE      8'h32
`define OFS_MODE_FOUR       8'h33
`define OFS_MODE_FIVE       8'h34
`define OFS_MODE_SIX        8'h35
`define OFS_LUMA_LEVEL      8'h36
`define OFS_RED_LEVEL       8'h37
`define OFS_BLUE_LEVEL      8'h38
`define RST_MODE_ONE        8'h00
`define RST_MODE_TWO        8'h00
`define RST_MODE_THREE      8'h00
`define RST_MODE_FOUR       8'h68
`define RST_MODE_FIVE       8'h48
`define RST_MODE_SIX        8'h00
`define RST_LUMA_LEVEL      8'hA0
`define RST_RED_LEVEL       8'h80
`define RST_BLUE_LEVEL      8'h80
`define LEVEL_LSB           0
`define LEVEL_RESERVED      2'h3
`define SYNC_EMBED_BIT      2
`define STD_LSB             3
`define STD_NONSTD          5'h01
`define STD_RSVD_A          5'h0B
`define STD_RSVD_B          5'h0C
`define STD_LAST            5'h12
`define PDV_BIT             0
`define OVS_BIT             1
`define TP_EN_BIT           2
`define TP_FLAT_BIT         3
`define VBI_OPEN_BIT        4
`define LUMA_DLY_LSB        0
`define CHROMA_DLY_LSB      3
`define CGMS_EN_BIT         6
`define CGMS_CRC_BIT        7
`define SINC_BIT            3
`define TRST_BIT            0
`define HS_CTL_BIT          1
`define VS_CTL_BIT          2
`define RSVD5_BIT           5
`define VSIN_SEL_BIT        6
`define CNT_FREE_BIT        7
`define SWAP_BIT            3
`define GAMMA_B_BIT         4
`define GAMMA_EN_BIT        5
`define AF_MODE_BIT         6
`define AF_EN_BIT           7
`endif

// ===== dv/host_model.sv
// Host model driving the write and read ports of the mode bank
`timescale 1ns/10ps
module host_model (
  input  wire       clk,
  input  wire [7:0] rd_data,
  output reg        wr_en,
  output reg  [7:0] wr_addr,
  output reg  [7:0] wr_data,
  output reg  [7:0] rd_addr
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end
  // One byte written; reserved bit five of 0x34 always sent as zero
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = (a == 8'h34) ? (d & 8'hDF) : d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  // Registered read data is settled at the following falling edge
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
  endtask
endmodule // host_model

// ===== dv/hd_mode_checker.sv
// Checker of the decoded controls of the mode bank
`timescale 1ns/10ps
module hd_mode_checker (
  input wire       clk,
  input wire       rst,
  input wire       clk_en,
  input wire       wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire       rd_valid,
  input wire [7:0] rd_data,
  input wire [1:0] level_mode,
  input wire       level_reserved,
  input wire       sync_embedded,
  input wire       ext_vsync_is_vsync,
  input wire       ext_vsync_is_field,
  input wire [4:0] video_std,
  input wire       std_nonstandard,
  input wire       std_reserved,
  input wire       pattern_on,
  input wire [7:0] pat_luma,
  input wire       timing_hold,
  input wire       counter_free,
  input wire       wrap_external,
  input wire       adapt_on,
  input wire       adapt_mode_b
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_LEVEL: assert property (level_reserved == (level_mode == 2'h3))
    else $error("level flag wrong");
  AST_SYNC: assert property ((ext_vsync_is_vsync || ext_vsync_is_field)
    |-> !sync_embedded && !(ext_vsync_is_vsync && ext_vsync_is_field))
    else $error("sync source wrong");
  AST_STD: assert property (std_reserved |-> video_std == 5'h01
    && std_nonstandard) else $error("reserved standard kept");
  AST_PAT: assert property (!pattern_on |-> pat_luma == 8'h00)
    else $error("pattern level leaks");
  AST_WRAP: assert property (wrap_external == (counter_free
    && !timing_hold)) else $error("wrap source wrong");
  AST_ADAPT: assert property (adapt_mode_b |-> adapt_on)
    else $error("adaptive mode without enable");
  AST_UNMAP: assert property (clk_en && !rd_valid |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  // Two edges: register first, then the decoded control
  AST_PAT_WR: assert property (clk_en && wr_en && wr_addr == 8'h31
    ##1 clk_en |=> pattern_on == $past(wr_data[2], 2))
    else $error("pattern enable late or wrong");
  cover property (std_reserved);
  cover property (wrap_external);
  cover property (clk_en && wr_en && wr_addr == 8'h31);
endmodule // hd_mode_checker
bind hd_video_mode_registers hd_mode_checker hd_mode_checker_i (
  .clk(clk), .rst(rst), .clk_en(clk_en), .wr_en(wr_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .rd_valid(rd_valid),
  .rd_data(rd_data), .level_mode(level_mode),
  .level_reserved(level_reserved), .sync_embedded(sync_embedded),
  .ext_vsync_is_vsync(ext_vsync_is_vsync),
  .ext_vsync_is_field(ext_vsync_is_field), .video_std(video_std),
  .std_nonstandard(std_nonstandard), .std_reserved(std_reserved),
  .pattern_on(pattern_on), .pat_luma(pat_luma),
  .timing_hold(timing_hold), .counter_free(counter_free),
  .wrap_external(wrap_external), .adapt_on(adapt_on),
  .adapt_mode_b(adapt_mode_b));

// ===== dv/hd_video_mode_registers_tb.sv
// Self-checking bench of the high definition mode bank
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  n_fail++; $display("Error %s exp %0h got %0h", n, e, a); end end
module hd_video_mode_registers_tb;
  logic        clk, rst, clk_en;
  wire         wr_en, rd_valid, level_reserved, sync_embedded;
  wire  [7:0]  wr_addr, wr_data, rd_addr, rd_data;
  wire  [7:0]  pat_luma, pat_red, pat_blue;
  wire  [4:0]  video_std;
  wire  [2:0]  luma_delay, chroma_delay;
  wire  [1:0]  level_mode;
  wire         ext_vsync_is_vsync, ext_vsync_is_field, std_nonstandard;
  wire         std_reserved, pixel_valid_on, oversample_2x, pattern_on;
  wire         pattern_flat, vbi_open, cgms_on, cgms_crc_on, sinc_on;
  wire         timing_hold, hsync_out_sel, vsync_out_sel, counter_free;
  wire         dac_swap, gamma_on, gamma_curve_b, adapt_on, adapt_mode_b;
  wire         wrap_external;
  int          n_fail, checks_done;
  logic [7:0]  v;
  // Rows: offset, reset value, value written and read back
  logic [23:0] rows [0:8] = '{24'h30005B, 24'h31001F, 24'h3200FF,
    24'h336808, 24'h3448C1, 24'h3500F8, 24'h36A012, 24'h378034, 24'h388056};
  hd_video_mode_registers hd_video_mode_registers_i (
    .clk(clk), .rst(rst), .clk_en(clk_en), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .level_mode(level_mode),
    .level_reserved(level_reserved), .sync_embedded(sync_embedded),
    .ext_vsync_is_vsync(ext_vsync_is_vsync),
    .ext_vsync_is_field(ext_vsync_is_field), .video_std(video_std),
    .std_nonstandard(std_nonstandard), .std_reserved(std_reserved),
    .pixel_valid_on(pixel_valid_on), .oversample_2x(oversample_2x),
    .pattern_on(pattern_on), .pattern_flat(pattern_flat),
    .vbi_open(vbi_open), .luma_delay(luma_delay),
    .chroma_delay(chroma_delay), .cgms_on(cgms_on),
    .cgms_crc_on(cgms_crc_on), .sinc_on(sinc_on),
    .timing_hold(timing_hold), .hsync_out_sel(hsync_out_sel),
    .vsync_out_sel(vsync_out_sel), .counter_free(counter_free),
    .dac_swap(dac_swap), .gamma_on(gamma_on),
    .gamma_curve_b(gamma_curve_b), .adapt_on(adapt_on),
    .adapt_mode_b(adapt_mode_b), .pat_luma(pat_luma), .pat_red(pat_red),
    .pat_blue(pat_blue), .wrap_external(wrap_external));
  host_model host_model_i (.clk(clk), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task complete_run;
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: a stuck sequence still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("sinc", 1'b1, sinc_on)
    `CHK("vsin", 3'h4, {ext_vsync_is_vsync, ext_vsync_is_field, counter_free})
    `CHK("patoff", 8'h00, pat_luma)
    for (int i = 0; i < 9; i++) begin
      host_model_i.rd(rows[i][23:16], v);
      `CHK("reset", rows[i][15:8], v)
      host_model_i.wr(rows[i][23:16], rows[i][7:0]);
      host_model_i.rd(rows[i][23:16], v);
      `CHK("rdback", rows[i][7:0], v)
    end
    `CHK("lvl", 3'h7, {level_reserved, level_mode})
    `CHK("std", 7'h61, {std_reserved, std_nonstandard, video_std})
    `CHK("m2", 5'h1F, {pattern_on, pattern_flat, vbi_open, pixel_valid_on, oversample_2x})
    `CHK("dly", 8'hFF, {cgms_crc_on, cgms_on, chroma_delay, luma_delay})
    `CHK("m5", 5'h18, {timing_hold, counter_free, wrap_external, hsync_out_sel, vsync_out_sel})
    `CHK("m6", 5'h1F, {dac_swap, gamma_curve_b, gamma_on, adapt_on, adapt_mode_b})
    `CHK("pat", 24'h123456, {pat_luma, pat_red, pat_blue})
    `CHK("vs", 2'h2, {ext_vsync_is_vsync, ext_vsync_is_field})
    host_model_i.wr(8'h34, 8'h80);
    host_model_i.wr(8'h30, 8'h04);
    @(negedge clk);
    `CHK("embed", 4'h9, {sync_embedded, ext_vsync_is_vsync, ext_vsync_is_field, wrap_external})
    host_model_i.wr(8'h30, 8'h90);
    @(negedge clk);
    `CHK("last", 8'h92, {ext_vsync_is_field, ext_vsync_is_vsync, std_reserved, video_std})
    host_model_i.wr(8'h30, 8'h98);
    host_model_i.wr(8'h34, 8'h06);
    @(negedge clk);
    `CHK("rsvd", 6'h21, {std_reserved, video_std})
    `CHK("hvsel", 3'h6, {hsync_out_sel, vsync_out_sel, timing_hold})
    host_model_i.rd(8'h39, v);
    `CHK("unmap", 9'h000, {rd_valid, v})
    host_model_i.wr(8'h31, 8'h00);
    @(negedge clk);
    `CHK("patgate", 8'h00, pat_luma)
    clk_en = 1'b0;
    host_model_i.wr(8'h31, 8'h04);
    clk_en = 1'b1;
    host_model_i.rd(8'h31, v);
    `CHK("freeze", 8'h00, v)
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    host_model_i.rd(8'h36, v);
    `CHK("rereset", 8'hA0, v)
    complete_run;
  end
endmodule // hd_video_mode_registers_tb
